// >>> include/add_exec_map.svh
`ifndef ADD_EXEC_MAP_SVH
`define ADD_EXEC_MAP_SVH

// Register word addresses on the Avalon-MM slave.
`define REG_CTRL        4'h0
`define REG_INSTR       4'h1
`define REG_ACC         4'h2
`define REG_BANK        4'h3
`define REG_FLAGS       4'h4
`define REG_BASE        4'h5
`define REG_STATE       4'h6

// Field positions.
`define CTRL_EXT_BIT    0
`define STATE_BUSY_BIT  0
`define STATE_ILL_BIT   1
`define FLAG_C_BIT      0
`define FLAG_DC_BIT     1
`define FLAG_Z_BIT      2
`define FLAG_OV_BIT     3
`define FLAG_N_BIT      4

// Reset values.
`define RST_ACC         8'h00
`define RST_BANK        4'h0
`define RST_BASE        12'h000
`define RST_INSTR       16'h0000

// Opcode patterns and addressing limits.
`define OP_LIT_ACC      8'h0f
`define OP_ACC_FILE     6'h09
`define ACCESS_SPLIT    8'h5f
`define ACCESS_HI_BANK  4'hf
`define ACCESS_LO_BANK  4'h0

`endif

// >>> include/add_exec_pkg.sv
package add_exec_pkg;

   // Phases of one instruction cycle, idle between instructions.
   typedef enum logic [2:0] {PH_IDLE, PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_e;

   // Arithmetic status flags.
   typedef struct packed {
      logic n;
      logic ov;
      logic z;
      logic dc;
      logic c;
   } flags_s;

   // Request to the banked data memory.
   typedef struct packed {
      logic [11:0] addr;
      logic        rd;
      logic        we;
      logic [7:0]  wdata;
   } mem_req_s;

endpackage : add_exec_pkg

// >>> rtl/add_exec_adder.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Eight-bit adder with status flags
// ----------------------------------------------------------------
module add_exec_adder
   import add_exec_pkg::*;
(
   // Operands.
   input  wire logic [7:0]           i_a,
   input  wire logic [7:0]           i_b,
   // Result.
   output logic [7:0]                o_sum,
   output add_exec_pkg::flags_s      o_flags
);

   logic [8:0] full;
   logic [4:0] low;

   // The nibble sum is kept apart so the digit carry is read straight off its bit 4.
   always_comb
   begin
      full          = {1'b0, i_a} + {1'b0, i_b};
      low           = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]};
      o_sum         = full[7:0];
      o_flags.c     = full[8];
      o_flags.dc    = low[4];
      o_flags.z     = (full[7:0] == 8'h00);
      o_flags.n     = full[7];
      // Overflow: like signs in, other sign out.
      o_flags.ov    = (i_a[7] == i_b[7]) && (full[7] != i_a[7]);
   end

endmodule : add_exec_adder

// >>> rtl/add_exec_addr.sv
`timescale 1ns/10ps
`include "add_exec_map.svh"
// ----------------------------------------------------------------
// File operand address resolution
// ----------------------------------------------------------------
module add_exec_addr
   import add_exec_pkg::*;
(
   // Operand fields.
   input  wire logic [7:0]           i_file,
   input  wire logic                 i_bank_sel,
   // Addressing state.
   input  wire logic [3:0]           i_bank,
   input  wire logic                 i_ext_en,
   input  wire logic [11:0]          i_base,
   // Resolved data memory address.
   output logic [11:0]               o_addr
);

   // Bank mode wins; otherwise indexed or plain access bank.
   always_comb
   begin
      if (i_bank_sel)
         o_addr = {i_bank, i_file};
      else if (i_ext_en && (i_file <= `ACCESS_SPLIT))
         o_addr = i_base + {4'h0, i_file};
      else if (i_file > `ACCESS_SPLIT)
         o_addr = {`ACCESS_HI_BANK, i_file};
      else
         o_addr = {`ACCESS_LO_BANK, i_file};
   end

endmodule : add_exec_addr

// >>> rtl/add_instruction_execute.sv
`timescale 1ns/10ps
`include "add_exec_map.svh"
// Function
// - Destination bit clear: sum into accumulator.
// - Destination bit set: sum into file.
// - Access select clear: use access bank.
// - Access select set: bank register picks bank.
// - Extended set, low addresses: indexed offset.
module add_instruction_execute
   import add_exec_pkg::*;
(
   // Clock and reset.
   input  wire logic                 i_core_clk,
   input  wire logic                 i_nrst,
   // Avalon-MM slave.
   input  wire logic [3:0]           i_address,
   input  wire logic                 i_read,
   input  wire logic                 i_write,
   input  wire logic [3:0]           i_byteenable,
   input  wire logic [31:0]          i_writedata,
   output logic [31:0]               o_readdata,
   output logic                      o_waitrequest,
   // Data memory.
   output add_exec_pkg::mem_req_s    o_mem,
   input  wire logic [7:0]           i_mem_rdata,
   // Status.
   output logic                      o_busy
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   phase_e      phase_reg,  phase_next;
   logic [15:0] instr_reg,  instr_next;
   logic [7:0]  opnd_reg,   opnd_next;
   logic [7:0]  res_reg,    res_next;
   flags_s      rflags_reg, rflags_next;
   mem_req_s    mem_reg,    mem_next;
   logic [7:0]  acc_reg,    acc_next;
   logic [3:0]  bank_reg,   bank_next;
   flags_s      flags_reg,  flags_next;
   logic        ext_reg,    ext_next;
   logic [11:0] base_reg,   base_next;
   logic        ill_reg,    ill_next;
   logic        ack_reg,    ack_next;
   logic [31:0] rdata_reg,  rdata_next;

   logic [7:0]  sum;
   flags_s      sum_flags;
   logic [11:0] file_addr;
   logic        is_lit;
   logic        is_file;
   logic        dest_file;
   logic        bank_sel;
   logic [7:0]  file_f;
   logic        wr_take;
   logic        instr_take;

   // Byte-lane merge of a written word into a stored one.
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  be);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (be[i])
            r[i*8 +: 8] = new_v[i*8 +: 8];
      end
      return r;
   endfunction : merge

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   // Fields come from the latched opcode so they hold for all phases.
   assign is_lit    = (instr_reg[15:8] == `OP_LIT_ACC);
   assign is_file   = (instr_reg[15:10] == `OP_ACC_FILE);
   assign dest_file = instr_reg[9];
   assign bank_sel  = instr_reg[8];
   assign file_f    = instr_reg[7:0];
   assign o_busy    = (phase_reg != PH_IDLE);
   assign o_mem     = mem_reg;

   add_exec_adder u_adder (
      .i_a     (acc_reg),
      .i_b     (opnd_reg),
      .o_sum   (sum),
      .o_flags (sum_flags)
   );

   add_exec_addr u_addr (
      .i_file     (file_f),
      .i_bank_sel (bank_sel),
      .i_bank     (bank_reg),
      .i_ext_en   (ext_reg),
      .i_base     (base_reg),
      .o_addr     (file_addr)
   );

   // ----------------------------------------------------------------
   // Avalon-MM slave
   // ----------------------------------------------------------------
   // Every access waits one cycle so read data comes from a flop.
   // Writes also wait while an instruction runs, which keeps software
   // from racing the execution unit on the accumulator or flags.
   always_comb
   begin
      ack_next   = (i_read || i_write) && !ack_reg && !(i_write && o_busy);
      rdata_next = 32'h0000_0000;
      unique case (i_address)
         `REG_CTRL:  rdata_next[`CTRL_EXT_BIT] = ext_reg;
         `REG_INSTR: rdata_next[15:0] = instr_reg;
         `REG_ACC:   rdata_next[7:0] = acc_reg;
         `REG_BANK:  rdata_next[3:0] = bank_reg;
         `REG_FLAGS: rdata_next[4:0] = flags_reg;
         `REG_BASE:  rdata_next[11:0] = base_reg;
         `REG_STATE:
         begin
            rdata_next[`STATE_BUSY_BIT] = o_busy;
            rdata_next[`STATE_ILL_BIT]  = ill_reg;
         end
         default:    rdata_next = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge i_core_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         ack_reg   <= 1'b0;
         rdata_reg <= 32'h0000_0000;
      end
      else
      begin
         ack_reg   <= ack_next;
         rdata_reg <= rdata_next;
      end
   end

   assign o_waitrequest = (i_read || i_write) && !ack_reg;
   assign o_readdata    = rdata_reg;
   assign wr_take       = i_write && ack_reg;
   assign instr_take    = wr_take && (i_address == `REG_INSTR);

   // ----------------------------------------------------------------
   // Instruction sequencer
   // ----------------------------------------------------------------
   always_comb
   begin
      phase_next  = phase_reg;
      instr_next  = instr_reg;
      opnd_next   = opnd_reg;
      res_next    = res_reg;
      rflags_next = rflags_reg;
      mem_next    = mem_reg;
      unique case (phase_reg)
         PH_IDLE:
         begin
            if (instr_take)
            begin
               instr_next = 16'(merge({16'h0000, instr_reg}, i_writedata, i_byteenable));
               phase_next = PH_Q1;
            end
         end
         PH_Q1:
         begin
            if (is_lit || is_file)
            begin
               mem_next.addr = file_addr;
               mem_next.rd   = is_file;
               phase_next    = PH_Q2;
            end
            else
               phase_next = PH_IDLE;
         end
         PH_Q2:
         begin
            opnd_next   = is_file ? i_mem_rdata : file_f;
            mem_next.rd = 1'b0;
            phase_next  = PH_Q3;
         end
         PH_Q3:
         begin
            res_next       = sum;
            rflags_next    = sum_flags;
            mem_next.we    = is_file && dest_file;
            mem_next.wdata = sum;
            phase_next     = PH_Q4;
         end
         PH_Q4:
         begin
            mem_next.we = 1'b0;
            phase_next  = PH_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_core_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         phase_reg  <= PH_IDLE;
         instr_reg  <= `RST_INSTR;
         opnd_reg   <= 8'h00;
         res_reg    <= 8'h00;
         rflags_reg <= '0;
         mem_reg    <= '0;
      end
      else
      begin
         phase_reg  <= phase_next;
         instr_reg  <= instr_next;
         opnd_reg   <= opnd_next;
         res_reg    <= res_next;
         rflags_reg <= rflags_next;
         mem_reg    <= mem_next;
      end
   end

   // ----------------------------------------------------------------
   // Architectural registers
   // ----------------------------------------------------------------
   // Software and the sequencer never write in the same cycle, since
   // bus writes are held off while busy.
   always_comb
   begin
      acc_next   = acc_reg;
      bank_next  = bank_reg;
      flags_next = flags_reg;
      ext_next   = ext_reg;
      base_next  = base_reg;
      ill_next   = ill_reg;
      if (wr_take)
      begin
         unique case (i_address)
            `REG_CTRL:  ext_next = i_byteenable[0] ? i_writedata[`CTRL_EXT_BIT] : ext_reg;
            `REG_ACC:   acc_next = 8'(merge({24'h0, acc_reg}, i_writedata,
                                            i_byteenable));
            `REG_BANK:  bank_next = 4'(merge({28'h0, bank_reg}, i_writedata,
                                             i_byteenable));
            `REG_FLAGS: flags_next = 5'(merge({27'h0, flags_reg}, i_writedata,
                                              i_byteenable));
            `REG_BASE:  base_next = 12'(merge({20'h0, base_reg}, i_writedata,
                                              i_byteenable));
            default:    ;
         endcase
      end
      // An opcode that is neither add is dropped and flagged.
      if (phase_reg == PH_Q1)
         ill_next = !(is_lit || is_file);
      if (phase_reg == PH_Q4)
      begin
         flags_next = rflags_reg;
         if (is_lit || !dest_file)
            acc_next = res_reg;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         acc_reg   <= `RST_ACC;
         bank_reg  <= `RST_BANK;
         flags_reg <= '0;
         ext_reg   <= 1'b0;
         base_reg  <= `RST_BASE;
         ill_reg   <= 1'b0;
      end
      else
      begin
         acc_reg   <= acc_next;
         bank_reg  <= bank_next;
         flags_reg <= flags_next;
         ext_reg   <= ext_next;
         base_reg  <= base_next;
         ill_reg   <= ill_next;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_acc_dest;
      @(posedge i_core_clk) disable iff (!i_nrst)
      (phase_reg == PH_Q4 && is_file && !dest_file)
      |=> (acc_reg == $past(res_reg)) && !o_mem.we;
   endproperty
   a_acc_dest: assert property (p_acc_dest)
      else $error("Accumulator did not take the sum.");

   property p_file_dest;
      @(posedge i_core_clk) disable iff (!i_nrst)
      (phase_reg == PH_Q4 && is_file && dest_file)
      |-> (o_mem.we && o_mem.wdata == res_reg) ##1 $stable(acc_reg);
   endproperty
   a_file_dest: assert property (p_file_dest)
      else $error("File write-back wrong or accumulator changed.");

   property p_access_bank;
      @(posedge i_core_clk) disable iff (!i_nrst)
      (phase_reg == PH_Q2 && is_file && !bank_sel
       && !(ext_reg && file_f <= `ACCESS_SPLIT))
      |-> o_mem.rd && o_mem.addr == {(file_f > `ACCESS_SPLIT) ?
          `ACCESS_HI_BANK : `ACCESS_LO_BANK, file_f};
   endproperty
   a_access_bank: assert property (p_access_bank)
      else $error("Access bank address wrong.");

   property p_bank_reg;
      @(posedge i_core_clk) disable iff (!i_nrst)
      (phase_reg == PH_Q2 && is_file && bank_sel)
      |-> o_mem.rd && o_mem.addr == {bank_reg, file_f};
   endproperty
   a_bank_reg: assert property (p_bank_reg)
      else $error("Banked address wrong.");

   property p_indexed;
      @(posedge i_core_clk) disable iff (!i_nrst)
      (phase_reg == PH_Q2 && is_file && !bank_sel && ext_reg
       && file_f <= `ACCESS_SPLIT)
      |-> o_mem.addr == base_reg + {4'h0, file_f};
   endproperty
   a_indexed: assert property (p_indexed)
      else $error("Indexed address wrong.");

   property p_one_cycle;
      @(posedge i_core_clk) disable iff (!i_nrst)
      (phase_reg == PH_Q1 && (is_lit || is_file))
      |=> phase_reg == PH_Q2 ##1 phase_reg == PH_Q3 ##1 phase_reg == PH_Q4
          ##1 phase_reg == PH_IDLE;
   endproperty
   a_one_cycle: assert property (p_one_cycle)
      else $error("Instruction did not finish in four phases.");

   property p_flags;
      @(posedge i_core_clk) disable iff (!i_nrst)
      (phase_reg == PH_Q3 && is_lit)
      ##1 (phase_reg == PH_Q4) |=> flags_reg == $past(rflags_reg, 1)
          && acc_reg == $past(res_reg, 1);
   endproperty
   a_flags: assert property (p_flags)
      else $error("Literal add did not update flags and accumulator.");

endmodule : add_instruction_execute

// >>> tb/data_mem_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Behavioural banked data memory
// ----------------------------------------------------------------
module data_mem_model
   import add_exec_pkg::*;
(
   // Clock.
   input  wire logic                 i_core_clk,
   // Request from the execute block.
   input  wire add_exec_pkg::mem_req_s i_mem,
   // Read data to the execute block.
   output logic [7:0]                o_rdata
);
   logic [7:0] mem [0:4095];

   // Seed every byte from its address, unique within each 256-byte bank, so a wrong address in the same bank shows up.
   initial
   begin
      for (int i = 0; i < 4096; i++)
         mem[i] = 8'(i * 37 + 11);
   end

   // Outside the read strobe the bus shows inverted data, so a late sample fails.
   assign o_rdata = (i_mem.rd === 1'b1) ? mem[i_mem.addr] : ~mem[i_mem.addr];

   // Byte write at the strobe edge.
   always @(posedge i_core_clk)
   begin
      if (i_mem.we === 1'b1)
         mem[i_mem.addr] <= i_mem.wdata;
   end
endmodule : data_mem_model

// >>> tb/tb_top.sv
`timescale 1ns/10ps
`include "add_exec_map.svh"
module tb_top;
   import add_exec_pkg::*;
   logic        i_core_clk, i_nrst, i_read, i_write, o_waitrequest, o_busy;
   logic [3:0]  i_address, i_byteenable, bank;
   logic [31:0] i_writedata, o_readdata;
   logic [7:0]  i_mem_rdata, acc, opnd, f, k;
   logic [11:0] base, ea;
   logic        ext, d, a;
   mem_req_s    o_mem;
   logic [31:0] rd_q[$];
   logic [11:0] addr_q[$];
   logic [19:0] wr_q[$];
   logic [19:0] wexp;
   int          n_mismatch, total_checks, cycles;

   add_instruction_execute dut (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
      .i_address(i_address), .i_read(i_read), .i_write(i_write),
      .i_byteenable(i_byteenable), .i_writedata(i_writedata), .o_readdata(o_readdata),
      .o_waitrequest(o_waitrequest), .o_mem(o_mem), .i_mem_rdata(i_mem_rdata),
      .o_busy(o_busy));
   data_mem_model u_mem (.i_core_clk(i_core_clk), .i_mem(o_mem), .o_rdata(i_mem_rdata));

   // ----------------------------------------------------------------
   // Clock, timeout and shared tasks
   // ----------------------------------------------------------------
   initial
   begin
      i_core_clk = 1'b0;
      forever #5 i_core_clk = ~i_core_clk;
   end

   // A hung handshake would otherwise stall the run forever.
   always @(posedge i_core_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_mismatch++;
         complete_run();
      end
   end

   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : complete_run

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // One Avalon transfer; the request is held until waitrequest is seen low.
   task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd,
                      input logic [3:0] be);
      @(posedge i_core_clk);
      i_read <= ~wr;
      i_write <= wr;
      i_address <= adr;
      i_writedata <= wd;
      i_byteenable <= be;
      @(posedge i_core_clk);
      while (o_waitrequest !== 1'b0)
         @(posedge i_core_clk);
      i_read <= 1'b0;
      i_write <= 1'b0;
   endtask : bus

   task automatic rd(input logic [3:0] adr, input logic [31:0] exp);
      rd_q.push_back(exp);
      bus(1'b0, adr, 32'h0, 4'hf);
   endtask : rd

   // Issues one opcode and counts the busy cycles it occupies.
   task automatic run(input logic [15:0] op, input logic [31:0] plen);
      logic [31:0] n;
      n = 32'h0;
      bus(1'b1, `REG_INSTR, {16'h0, op}, 4'hf);
      #1;
      while (o_busy === 1'b1)
      begin
         n++;
         @(posedge i_core_clk);
         #1;
      end
      check("busy_cycles", n, plen);
   endtask : run

   function automatic logic [31:0] flg(input logic [7:0] x, input logic [7:0] y);
      logic [8:0] s;
      logic       h;
      s = {1'b0, x} + {1'b0, y};
      h = ({1'b0, x[3:0]} + {1'b0, y[3:0]}) > 5'h0f;
      return {27'h0, s[7], (x[7] == y[7]) && (s[7] != x[7]), s[7:0] == 8'h00, h, s[8]};
   endfunction : flg

   // ----------------------------------------------------------------
   // Output monitor: each result is matched to the oldest note
   // ----------------------------------------------------------------
   always @(posedge i_core_clk)
   begin
      if (i_read === 1'b1 && o_waitrequest === 1'b0)
         check("readdata", o_readdata, rd_q.size() ? rd_q.pop_front() : 32'hx);
      if (o_mem.rd === 1'b1)
         check("mem_addr", o_mem.addr, addr_q.size() ? addr_q.pop_front() : 12'hx);
      if (o_mem.we === 1'b1)
      begin
         wexp = wr_q.size() ? wr_q.pop_front() : 20'hx;
         check("mem_write", {o_mem.addr, o_mem.wdata}, wexp);
      end
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      {i_nrst, i_read, i_write, i_address, i_byteenable, i_writedata} = '0;
      repeat (20) @(posedge i_core_clk);
      i_nrst <= 1'b1;
      void'($urandom(35668));
      // Reset values, two of the unmapped words and the read-only status word.
      for (int r = 0; r < 9; r++)
         rd(4'(r), 32'h0);
      bus(1'b1, `REG_STATE, 32'hffffffff, 4'hf);
      rd(`REG_STATE, 32'h0);
      bus(1'b1, `REG_BANK, 32'hffffffff, 4'hf);
      rd(`REG_BANK, 32'hf);
      // Flags are software writable, and only five bits exist.
      bus(1'b1, `REG_FLAGS, 32'hffffffff, 4'hf);
      rd(`REG_FLAGS, 32'h1f);
      // The enable bit lives in the low lane, so a masked write is lost.
      bus(1'b1, `REG_CTRL, 32'h1, 4'he);
      rd(`REG_CTRL, 32'h0);
      // A write with the low lane disabled must leave the accumulator alone.
      bus(1'b1, `REG_ACC, 32'h55, 4'hf);
      bus(1'b1, `REG_ACC, 32'haa, 4'he);
      rd(`REG_ACC, 32'h55);
      // Literal adds, with carry, zero and overflow corners first.
      for (int i = 0; i < 10; i++)
      begin
         acc = (i == 0) ? 8'hff : (i == 1) ? 8'h7f : (i == 2) ? 8'h10 : 8'($urandom);
         k = (i < 2) ? 8'h01 : (i == 2) ? 8'h15 : 8'($urandom);
         bus(1'b1, `REG_ACC, {24'h0, acc}, 4'hf);
         run({`OP_LIT_ACC, k}, 32'h4);
         rd(`REG_FLAGS, flg(acc, k));
         acc = acc + k;
         rd(`REG_ACC, {24'h0, acc});
      end
      // File adds over every destination, bank mode and boundary address.
      for (int i = 0; i < 32; i++)
      begin
         d = i[0];
         a = i[1];
         ext = i[2];
         f = i[3] ? 8'($urandom) : (i[4] ? `ACCESS_SPLIT : 8'h60);
         bank = 4'($urandom);
         base = 12'($urandom);
         acc = 8'($urandom);
         bus(1'b1, `REG_BANK, {28'h0, bank}, 4'hf);
         bus(1'b1, `REG_BASE, {20'h0, base}, 4'hf);
         bus(1'b1, `REG_CTRL, {31'h0, ext}, 4'hf);
         bus(1'b1, `REG_ACC, {24'h0, acc}, 4'hf);
         if (a)
            ea = {bank, f};
         else if (ext && f <= `ACCESS_SPLIT)
            ea = base + {4'h0, f};
         else
            ea = {(f > `ACCESS_SPLIT) ? `ACCESS_HI_BANK : `ACCESS_LO_BANK, f};
         opnd = u_mem.mem[ea];
         addr_q.push_back(ea);
         if (d)
            wr_q.push_back({ea, 8'(acc + opnd)});
         run({`OP_ACC_FILE, d, a, f}, 32'h4);
         rd(`REG_FLAGS, flg(acc, opnd));
         rd(`REG_ACC, {24'h0, d ? acc : 8'(acc + opnd)});
      end
      // An unknown opcode is flagged, then cleared by the next valid one.
      run(16'hffff, 32'h1);
      rd(`REG_STATE, 32'h2);
      run({`OP_LIT_ACC, 8'h00}, 32'h4);
      rd(`REG_STATE, 32'h0);
      repeat (4) @(posedge i_core_clk);
      check("queues_empty", rd_q.size() + addr_q.size() + wr_q.size(), 32'h0);
      complete_run();
   end
endmodule : tb_top
